//--- rtl/anpr_mdio_serial.sv
// serial management frame engine: preamble, header, turnaround, data
// assumes mdc is far slower than clk and synchronous to it
`timescale 1ns/1ps
module anpr_mdio_serial (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        mdc,
    input  wire logic        mdio_in,
    input  wire logic [4:0]  phy_addr,
    input  wire logic [15:0] rd_data,
    output logic             mdio_out,
    output logic             mdio_oe_n,
    output logic             rd_req,
    output logic             wr_req,
    output logic [4:0]       reg_addr,
    output logic [15:0]      wr_data
);
    typedef enum logic [1:0] {S_PRE, S_HDR, S_TA, S_DATA} anpr_mdio_state_t;

    anpr_mdio_state_t state, next_state;
    logic             mdc_q;
    logic [5:0]       cnt, next_cnt;
    logic [12:0]      hdr, next_hdr;
    logic [15:0]      shift, next_shift;
    logic             is_read, next_is_read;
    logic             next_mdio_out, next_mdio_oe_n;
    logic             next_rd_req, next_wr_req;
    logic [4:0]       next_reg_addr;
    logic [15:0]      next_wr_data;
    logic [12:0]      full;
    logic             mdc_rise;

    assign mdc_rise = mdc & ~mdc_q;
    assign full     = {hdr[11:0], mdio_in};

    // frame sequencing, all moves on a rising management clock
    always_comb begin
        next_state     = state;
        next_cnt       = cnt;
        next_hdr       = hdr;
        next_shift     = shift;
        next_is_read   = is_read;
        next_mdio_out  = mdio_out;
        next_mdio_oe_n = mdio_oe_n;
        next_rd_req    = 1'b0;
        next_wr_req    = 1'b0;
        next_reg_addr  = reg_addr;
        next_wr_data   = wr_data;
        if (mdc_rise) begin
            unique case (state)
                S_PRE: begin
                    if (mdio_in) begin
                        if (cnt != anpr_pkg::PRE_LEN) begin
                            next_cnt = cnt + 6'h01;
                        end
                    end else if (cnt == anpr_pkg::PRE_LEN) begin
                        next_state = S_HDR;
                        next_cnt   = 6'h00;
                    end else begin
                        next_cnt = 6'h00;
                    end
                end
                S_HDR: begin
                    next_hdr = full;
                    next_cnt = cnt + 6'h01;
                    if (cnt == anpr_pkg::HDR_LAST) begin
                        // foreign address or bad opcode drops back to preamble hunt
                        next_cnt      = 6'h00;
                        next_state    = S_PRE;
                        next_reg_addr = full[4:0];
                        if (full[12] && full[9:5] == phy_addr) begin
                            if (full[11:10] == anpr_pkg::OP_READ) begin
                                next_state   = S_TA;
                                next_is_read = 1'b1;
                                next_rd_req  = 1'b1;
                            end else if (full[11:10] == anpr_pkg::OP_WRITE) begin
                                next_state   = S_TA;
                                next_is_read = 1'b0;
                            end
                        end
                    end
                end
                S_TA: begin
                    // second turnaround bit is driven low on reads
                    if (is_read) begin
                        next_mdio_out  = 1'b0;
                        next_mdio_oe_n = 1'b0;
                        next_shift     = rd_data;
                    end
                    next_state = S_DATA;
                    next_cnt   = 6'h00;
                end
                S_DATA: begin
                    next_cnt = cnt + 6'h01;
                    if (is_read) begin
                        next_mdio_out = shift[15];
                        next_shift    = {shift[14:0], 1'b0};
                    end else begin
                        next_shift = {shift[14:0], mdio_in};
                    end
                    if (cnt == anpr_pkg::DATA_LAST) begin
                        next_state     = S_PRE;
                        next_cnt       = 6'h00;
                        next_mdio_out  = 1'b1;
                        next_mdio_oe_n = 1'b1;
                        next_wr_req    = ~is_read;
                        next_wr_data   = {shift[14:0], mdio_in};
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state     <= S_PRE;
            mdc_q     <= 1'b0;
            cnt       <= 6'h00;
            hdr       <= 13'h0000;
            shift     <= 16'h0000;
            is_read   <= 1'b0;
            mdio_out  <= 1'b1;
            mdio_oe_n <= 1'b1;
            rd_req    <= 1'b0;
            wr_req    <= 1'b0;
            reg_addr  <= 5'h00;
            wr_data   <= 16'h0000;
        end else begin
            state     <= next_state;
            mdc_q     <= mdc;
            cnt       <= next_cnt;
            hdr       <= next_hdr;
            shift     <= next_shift;
            is_read   <= next_is_read;
            mdio_out  <= next_mdio_out;
            mdio_oe_n <= next_mdio_oe_n;
            rd_req    <= next_rd_req;
            wr_req    <= next_wr_req;
            reg_addr  <= next_reg_addr;
            wr_data   <= next_wr_data;
        end
    end
endmodule

//--- rtl/anpr_next_page_regs.sv
// next-page register slice with expansion flags and pll control bit
// assumes the negotiation engine gives one-cycle page pulses in the clk domain
`timescale 1ns/1ps
module anpr_next_page_regs (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        mdc,
    input  wire logic        mdio_in,
    output logic             mdio_out,
    output logic             mdio_oe_n,
    input  wire logic [4:0]  phy_addr,
    input  wire logic        an_page_rcvd,
    input  wire logic [15:0] an_rx_page,
    input  wire logic        an_partner_able,
    input  wire logic        an_tx_toggle,
    input  wire logic        energy_detect_power_down,
    output logic             np_tx_message_page,
    output logic             np_tx_comply_ack,
    output logic [10:0]      np_tx_message,
    output logic             pll_off
);
    logic        rd_req, wr_req;
    logic [4:0]  reg_addr;
    logic [15:0] wr_data;
    logic [15:0] rd_data, next_rd_data, rd_value;
    logic        page_rcvd, next_page_rcvd;
    logic        partner_able, tx_toggle;
    logic [15:0] np_rx, next_np_rx;
    logic        next_np_tx_message_page, next_np_tx_comply_ack;
    logic [10:0] next_np_tx_message;
    logic [15:0] dig_ctrl, next_dig_ctrl;
    logic [9:0]  ana_rsv, next_ana_rsv;
    logic        next_pll_off;

    // ****************************************
    // serial port
    // ****************************************
    anpr_mdio_serial u_serial (
        .clk       (clk),
        .reset_n   (reset_n),
        .mdc       (mdc),
        .mdio_in   (mdio_in),
        .phy_addr  (phy_addr),
        .rd_data   (rd_data),
        .mdio_out  (mdio_out),
        .mdio_oe_n (mdio_oe_n),
        .rd_req    (rd_req),
        .wr_req    (wr_req),
        .reg_addr  (reg_addr),
        .wr_data   (wr_data)
    );

    // ****************************************
    // register file
    // ****************************************
    // read view; unmapped offsets read zero
    always_comb begin
        rd_value = 16'h0000;
        unique case (reg_addr)
            anpr_pkg::ADDR_EXP: begin
                rd_value[anpr_pkg::EXP_NP_ABLE]   = anpr_pkg::NP_ABLE_VAL;
                rd_value[anpr_pkg::EXP_PAGE_RCVD] = page_rcvd;
                rd_value[anpr_pkg::EXP_LP_ABLE]   = partner_able;
            end
            anpr_pkg::ADDR_NP_TX: begin
                rd_value[anpr_pkg::NP_MSG_PAGE]       = np_tx_message_page;
                rd_value[anpr_pkg::NP_ACK2]           = np_tx_comply_ack;
                rd_value[anpr_pkg::NP_TOGGLE]         = tx_toggle;
                rd_value[anpr_pkg::NP_MSG_MSB:0]      = np_tx_message;
            end
            anpr_pkg::ADDR_NP_RX: rd_value = np_rx;
            anpr_pkg::ADDR_DIG:   rd_value = dig_ctrl;
            // low six bits belong to other analog controls and read zero here
            anpr_pkg::ADDR_ANA:   rd_value[15:anpr_pkg::ANA_RSV_LSB] = ana_rsv;
            default:              rd_value = 16'h0000;
        endcase
    end

    // next register state from host writes and engine events
    always_comb begin
        next_rd_data            = rd_data;
        next_np_tx_message_page = np_tx_message_page;
        next_np_tx_comply_ack   = np_tx_comply_ack;
        next_np_tx_message      = np_tx_message;
        next_dig_ctrl           = dig_ctrl;
        next_ana_rsv            = ana_rsv;
        if (rd_req) begin
            next_rd_data = rd_value;
        end
        // new page sets and wins over a read clear
        next_page_rcvd = an_page_rcvd |
                         (page_rcvd & ~(rd_req && reg_addr == anpr_pkg::ADDR_EXP));
        next_np_rx = an_page_rcvd ? an_rx_page : np_rx;
        // only writable fields take host data
        if (wr_req) begin
            unique case (reg_addr)
                anpr_pkg::ADDR_NP_TX: begin
                    next_np_tx_message_page = wr_data[anpr_pkg::NP_MSG_PAGE];
                    next_np_tx_comply_ack   = wr_data[anpr_pkg::NP_ACK2];
                    next_np_tx_message      = wr_data[anpr_pkg::NP_MSG_MSB:0];
                end
                anpr_pkg::ADDR_DIG: next_dig_ctrl = wr_data;
                anpr_pkg::ADDR_ANA: next_ana_rsv  = wr_data[15:anpr_pkg::ANA_RSV_LSB];
                default: begin
                end
            endcase
        end
        // registered so the pin cannot glitch while the mode inputs settle
        // pll drops only when enabled and in power-down
        next_pll_off = dig_ctrl[anpr_pkg::DIG_PLL_OFF] & energy_detect_power_down;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data            <= 16'h0000;
            page_rcvd          <= 1'b0;
            partner_able       <= 1'b0;
            tx_toggle          <= 1'b0;
            np_rx              <= anpr_pkg::NP_RX_RST;
            np_tx_message_page <= anpr_pkg::NP_TX_MP_RST;
            np_tx_comply_ack   <= anpr_pkg::NP_TX_ACK2_RST;
            np_tx_message      <= anpr_pkg::NP_TX_MSG_RST;
            dig_ctrl           <= anpr_pkg::DIG_RST;
            ana_rsv            <= anpr_pkg::ANA_RSV_RST;
            pll_off            <= 1'b0;
        end else begin
            rd_data            <= next_rd_data;
            page_rcvd          <= next_page_rcvd;
            partner_able       <= an_partner_able;
            tx_toggle          <= an_tx_toggle;
            np_rx              <= next_np_rx;
            np_tx_message_page <= next_np_tx_message_page;
            np_tx_comply_ack   <= next_np_tx_comply_ack;
            np_tx_message      <= next_np_tx_message;
            dig_ctrl           <= next_dig_ctrl;
            ana_rsv            <= next_ana_rsv;
            pll_off            <= next_pll_off;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    // checks sleep through reset so $past never reports reset values
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // decoded strobes shared by the checks below
    logic rd_exp, wr_np_tx, rd_np_rx, rd_ana, wr_dig;
    assign rd_exp   = rd_req && reg_addr == anpr_pkg::ADDR_EXP;
    assign wr_np_tx = wr_req && reg_addr == anpr_pkg::ADDR_NP_TX;
    assign rd_np_rx = rd_req && reg_addr == anpr_pkg::ADDR_NP_RX;
    assign rd_ana   = rd_req && reg_addr == anpr_pkg::ADDR_ANA;
    assign wr_dig   = wr_req && reg_addr == anpr_pkg::ADDR_DIG;

    // expansion register: fixed ability, latched page flag, partner ability
    a_np_able_one: assert property (rd_exp |=> rd_data[anpr_pkg::EXP_NP_ABLE])
        else $error("next page able bit read zero");
    a_page_sets: assert property (an_page_rcvd |=> page_rcvd [*1] ##1 (page_rcvd || $past(rd_exp)))
        else $error("page received flag did not latch");
    a_page_wins: assert property (an_page_rcvd && rd_exp |=> page_rcvd)
        else $error("read clear beat a new page");
    a_page_clears: assert property (rd_exp && page_rcvd && !an_page_rcvd
                                    |=> rd_data[anpr_pkg::EXP_PAGE_RCVD] && !page_rcvd)
        else $error("page received flag not shown or not cleared");
    a_lp_able_view: assert property (rd_exp |=> rd_data[anpr_pkg::EXP_LP_ABLE] == $past(partner_able))
        else $error("partner ability bit mismatch");
    a_exp_upper_zero: assert property (rd_exp |=> rd_data[15:anpr_pkg::EXP_NP_ABLE + 1] == 13'h0000)
        else $error("expansion upper bits not zero");
    // local next page: writable fields follow host data, toggle is read-only
    a_np_tx_fields: assert property (wr_np_tx |=> np_tx_message == $past(wr_data[anpr_pkg::NP_MSG_MSB:0])
                                     && np_tx_message_page == $past(wr_data[anpr_pkg::NP_MSG_PAGE]))
        else $error("local message write lost");
    a_comply_write: assert property (wr_np_tx |=> np_tx_comply_ack == $past(wr_data[anpr_pkg::NP_ACK2]))
        else $error("comply acknowledge write lost");
    a_toggle_read: assert property (rd_req && reg_addr == anpr_pkg::ADDR_NP_TX
                                    |=> rd_data[anpr_pkg::NP_TOGGLE] == $past(tx_toggle) && rd_data[15:14] == 2'h0)
        else $error("local toggle or reserved bits wrong");
    // partner page: captured whole on the pulse, never by the host
    a_partner_load: assert property (an_page_rcvd |=> np_rx == $past(an_rx_page))
        else $error("partner page not captured");
    a_partner_view: assert property (rd_np_rx |=> rd_data == $past(np_rx))
        else $error("partner page read back wrong");
    a_partner_ro: assert property (wr_req && reg_addr == anpr_pkg::ADDR_NP_RX && !an_page_rcvd
                                   |=> $stable(np_rx))
        else $error("host write changed partner page");
    a_ana_low_zero: assert property (rd_ana |=> rd_data[anpr_pkg::ANA_RSV_LSB - 1:0] == 6'h00)
        else $error("analog low bits not zero");
    // pll control
    a_pll_kept_on: assert property ((!dig_ctrl[anpr_pkg::DIG_PLL_OFF]) [*2] |-> !pll_off)
        else $error("pll switched off while disabled");
    a_pll_follows: assert property (dig_ctrl[anpr_pkg::DIG_PLL_OFF] && energy_detect_power_down |=> pll_off)
        else $error("pll kept on in power-down");
    a_dig_write: assert property (wr_dig |=> dig_ctrl == $past(wr_data))
        else $error("control register write lost");

    // covers: the scenarios the bench is meant to reach
    c_page_read: cover property (an_page_rcvd ##[1:1000] rd_exp);
    c_np_tx_write: cover property (wr_np_tx);
    c_pll_off: cover property ($rose(pll_off));
    c_np_rx_read: cover property (rd_np_rx);
    c_ana_write: cover property (wr_req && reg_addr == anpr_pkg::ADDR_ANA);
endmodule

//--- rtl/anpr_pkg.sv
// constants for the next-page register slice and its serial management port
// assumes one 40 MHz core clock and a management clock sampled as a plain input
package anpr_pkg;
    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [4:0] ADDR_EXP   = 5'h06;
    localparam logic [4:0] ADDR_NP_TX = 5'h07;
    localparam logic [4:0] ADDR_NP_RX = 5'h08;
    localparam logic [4:0] ADDR_DIG   = 5'h10;
    localparam logic [4:0] ADDR_ANA   = 5'h11;
    // ****************************************
    // field positions
    // ****************************************
    localparam int EXP_NP_ABLE   = 2;
    localparam int EXP_PAGE_RCVD = 1;
    localparam int EXP_LP_ABLE   = 0;
    localparam int NP_MORE       = 15;
    localparam int NP_ACK        = 14;
    localparam int NP_MSG_PAGE   = 13;
    localparam int NP_ACK2       = 12;
    localparam int NP_TOGGLE     = 11;
    localparam int NP_MSG_MSB    = 10;
    localparam int DIG_PLL_OFF   = 4;
    localparam int ANA_RSV_LSB   = 6;
    // ****************************************
    // reset values
    // ****************************************
    localparam logic        NP_TX_MP_RST   = 1'h1;
    localparam logic        NP_TX_ACK2_RST = 1'h0;
    localparam logic [10:0] NP_TX_MSG_RST  = 11'h001;
    localparam logic [15:0] NP_RX_RST      = 16'h0000;
    localparam logic [15:0] DIG_RST        = 16'h0000;
    localparam logic [9:0]  ANA_RSV_RST    = 10'h000;
    localparam logic        NP_ABLE_VAL    = 1'h1;
    // ****************************************
    // serial frame
    // ****************************************
    localparam logic [5:0] PRE_LEN   = 6'h20;
    localparam logic [5:0] HDR_LAST  = 6'h0C;
    localparam logic [5:0] DATA_LAST = 6'h10;
    localparam logic [1:0] OP_READ   = 2'h2;
    localparam logic [1:0] OP_WRITE  = 2'h1;
endpackage

//--- verif/anpr_mdio_host.sv
// management host model: bit-bangs serial frames on mdc and mdio
// assumes clk is seven times faster than mdc; mdio has a pull-up
`timescale 1ns/1ps
module anpr_mdio_host (
    input  wire logic clk,
    input  wire logic mdio_out,
    input  wire logic mdio_oe_n,
    output logic      mdc,
    output logic      mdio_in
);
    logic host_en;
    logic host_bit;

    // ****************************************
    // wire level
    // ****************************************
    // a released line floats high through the pull-up, never the last value
    assign mdio_in = host_en ? host_bit : (!mdio_oe_n ? mdio_out : 1'b1);

    // idle: clock parked low, host holding the line high
    initial begin
        mdc      = 1'b0;
        host_en  = 1'b1;
        host_bit = 1'b1;
    end

    // ****************************************
    // one frame: preamble, header, turnaround, data
    // ****************************************
    // mdc stands still between frames; it stays low for three clk cycles and high for four
    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] regad,
                         input logic [15:0] wdata, output logic [15:0] rdata);
        logic [63:0] bits;
        bits  = {32'hFFFFFFFF, 2'h1, op, phy, regad, 2'h2, wdata};
        rdata = 16'h0000;
        for (int p = 0; p < 64; p++) begin
            @(negedge clk);
            mdc      = 1'b0;
            host_en  = !(op == anpr_pkg::OP_READ && p >= 46);
            host_bit = bits[63-p];
            repeat (3) @(negedge clk);
            // sample just before the rise, nearly a full mdc period after the device moved
            if (p >= 48) begin
                rdata[63-p] = mdio_in;
            end
            mdc = 1'b1;
            repeat (3) @(negedge clk);
        end
        @(negedge clk);
        mdc      = 1'b0;
        host_en  = 1'b1;
        host_bit = 1'b1;
        repeat (4) @(negedge clk);
    endtask
endmodule

//--- verif/anpr_next_page_regs_tb.sv
// testbench for the next-page register slice, driven through its serial port
// assumes the host model in anpr_mdio_host and a 40 MHz core clock
`timescale 1ns/1ps
module anpr_next_page_regs_tb;
    localparam logic [4:0] PHY = 5'h03;
    logic        clk;
    logic        reset_n;
    logic        mdc;
    logic        mdio_in;
    logic        mdio_out;
    logic        mdio_oe_n;
    logic        an_page_rcvd;
    logic [15:0] an_rx_page;
    logic        an_partner_able;
    logic        an_tx_toggle;
    logic        energy_detect_power_down;
    logic        np_tx_message_page;
    logic        np_tx_comply_ack;
    logic [10:0] np_tx_message;
    logic        pll_off;
    logic [15:0] junk;
    int          err_count;
    int          comparisons;

    anpr_next_page_regs dut_u (.clk(clk), .reset_n(reset_n), .mdc(mdc), .mdio_in(mdio_in),
        .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .phy_addr(PHY), .an_page_rcvd(an_page_rcvd),
        .an_rx_page(an_rx_page), .an_partner_able(an_partner_able), .an_tx_toggle(an_tx_toggle),
        .energy_detect_power_down(energy_detect_power_down), .np_tx_message_page(np_tx_message_page),
        .np_tx_comply_ack(np_tx_comply_ack), .np_tx_message(np_tx_message), .pll_off(pll_off));
    anpr_mdio_host host_u (.clk(clk), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .mdc(mdc),
        .mdio_in(mdio_in));

    // ****************************************
    // clock, compare and access tasks
    // ****************************************
    always #12.5 clk = ~clk;

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rd(input logic [4:0] a, input logic [15:0] exp, input string what);
        logic [15:0] d;
        host_u.frame(anpr_pkg::OP_READ, PHY, a, 16'h0000, d);
        check(what, d, exp);
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        host_u.frame(anpr_pkg::OP_WRITE, PHY, a, d, junk);
    endtask

    // transmit-side outputs packed as {3'h0, message page, comply ack, message}
    task automatic tx_out(input logic [15:0] exp);
        check("tx outputs", {3'h0, np_tx_message_page, np_tx_comply_ack, np_tx_message}, exp);
    endtask

    task automatic page(input logic [15:0] w);
        @(negedge clk);
        an_rx_page   = w;
        an_page_rcvd = 1'b1;
        @(negedge clk);
        an_page_rcvd = 1'b0;
        an_rx_page   = 16'h0000; // a later change must not leak into the stored page
    endtask

    task automatic final_report;
        $display("counts: %0d comparisons, %0d mismatches", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // watchdog: the whole sequence needs well under a millisecond
    initial begin
        #1000000;
        err_count++;
        final_report();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        clk = 1'b0; reset_n = 1'b0; an_page_rcvd = 1'b0; an_rx_page = 16'h0000;
        an_partner_able = 1'b0; an_tx_toggle = 1'b0; energy_detect_power_down = 1'b0;
        err_count = 0; comparisons = 0;
        repeat (16) @(negedge clk);
        reset_n = 1'b1;
        rd(anpr_pkg::ADDR_EXP, 16'h0004, "exp reset"); // ability bits
        rd(anpr_pkg::ADDR_NP_TX, 16'h2001, "tx reset"); // local page
        rd(anpr_pkg::ADDR_NP_RX, 16'h0000, "rx reset"); // partner page
        rd(anpr_pkg::ADDR_DIG, 16'h0000, "dig reset"); // control bit
        rd(anpr_pkg::ADDR_ANA, 16'h0000, "analog reset"); // reserved storage
        tx_out(16'h1001); // outputs at reset
        $display("test reset values done");
        wr(anpr_pkg::ADDR_NP_TX, 16'hFFFF);
        rd(anpr_pkg::ADDR_NP_TX, 16'h37FF, "tx all ones"); // read-only bits kept
        tx_out(16'h1FFF); // outputs follow writes
        an_tx_toggle = 1'b1;
        rd(anpr_pkg::ADDR_NP_TX, 16'h3FFF, "tx toggle set"); // toggle follows state
        wr(anpr_pkg::ADDR_NP_TX, 16'h0000);
        rd(anpr_pkg::ADDR_NP_TX, 16'h0800, "tx zeros"); // fields cleared
        tx_out(16'h0000); // outputs cleared
        wr(anpr_pkg::ADDR_NP_TX, 16'h07FF);
        rd(anpr_pkg::ADDR_NP_TX, 16'h0FFF, "tx message max"); // top message code
        $display("test local page done");
        an_partner_able = 1'b1;
        page(16'hD9A5);
        rd(anpr_pkg::ADDR_EXP, 16'h0007, "exp page set"); // flag latched
        rd(anpr_pkg::ADDR_EXP, 16'h0005, "exp after read"); // cleared by read
        rd(anpr_pkg::ADDR_NP_RX, 16'hD9A5, "rx page one"); // captured
        wr(anpr_pkg::ADDR_NP_RX, 16'h0000);
        rd(anpr_pkg::ADDR_NP_RX, 16'hD9A5, "rx write ignored"); // read-only register
        page(16'h2E5A);
        an_partner_able = 1'b0;
        rd(anpr_pkg::ADDR_NP_RX, 16'h2E5A, "rx page two"); // inverse of page one except bit 11
        rd(anpr_pkg::ADDR_EXP, 16'h0006, "exp second page"); // partner not able
        wr(anpr_pkg::ADDR_EXP, 16'hFFFF);
        rd(anpr_pkg::ADDR_EXP, 16'h0004, "exp write ignored"); // read-only bits
        $display("test partner page done");
        wr(anpr_pkg::ADDR_DIG, 16'hFFFF);
        rd(anpr_pkg::ADDR_DIG, 16'hFFFF, "dig all ones"); // writable bits kept
        energy_detect_power_down = 1'b1;
        repeat (3) @(negedge clk);
        check("pll on enable", {15'h0000, pll_off}, 16'h0001); // pll off in power-down
        energy_detect_power_down = 1'b0;
        repeat (3) @(negedge clk);
        check("pll awake", {15'h0000, pll_off}, 16'h0000); // pll on outside power-down
        wr(anpr_pkg::ADDR_DIG, 16'hFFEF);
        energy_detect_power_down = 1'b1;
        repeat (3) @(negedge clk);
        check("pll kept on", {15'h0000, pll_off}, 16'h0000); // bit clear keeps pll on
        rd(anpr_pkg::ADDR_DIG, 16'hFFEF, "dig bit four"); // control bit readback
        wr(anpr_pkg::ADDR_ANA, 16'hFFFF);
        rd(anpr_pkg::ADDR_ANA, 16'hFFC0, "analog reserved"); // reserved storage kept
        rd(5'h1F, 16'h0000, "unmapped"); // unmapped reads zero
        host_u.frame(anpr_pkg::OP_WRITE, 5'h04, anpr_pkg::ADDR_DIG, 16'h0000, junk);
        host_u.frame(anpr_pkg::OP_READ, 5'h04, anpr_pkg::ADDR_DIG, 16'h0000, junk);
        check("other address read", junk, 16'hFFFF); // no answer to another address
        rd(anpr_pkg::ADDR_DIG, 16'hFFEF, "other address write"); // write ignored
        $display("test control bits done");
        @(negedge clk);
        reset_n = 1'b0;
        repeat (2) @(negedge clk);
        tx_out(16'h1001); // outputs back to reset
        check("pll in reset", {15'h0000, pll_off}, 16'h0000); // pll control cleared
        reset_n = 1'b1;
        rd(anpr_pkg::ADDR_NP_TX, 16'h2801, "tx after reset"); // toggle still high
        rd(anpr_pkg::ADDR_DIG, 16'h0000, "dig after reset"); // back to zero
        $display("test mid-run reset done");
        final_report();
    end
endmodule
